// ### inc/crx_pkg.sv
// Constants, register layout and carrier types for the receive flag and enable block
package crx_pkg;
  // Register indexes; byte address is four times the index
  localparam logic [7:0] FLAG_IDX = 8'h04;
  localparam logic [7:0] IRQ_EN_IDX = 8'h05;
  localparam logic [7:0] FLAG_ADDR = {FLAG_IDX[5:0], 2'b00};
  localparam logic [7:0] IRQ_EN_ADDR = {IRQ_EN_IDX[5:0], 2'b00};

  // Bit positions shared by the flag register and the enable register
  localparam int WAKE_BIT = 7;
  localparam int SC_BIT = 6;
  localparam int RX_CODE_LO = 4;
  localparam int TX_CODE_LO = 2;
  localparam int OVR_BIT = 1;
  localparam int RXF_BIT = 0;

  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET = 8'h00;
  localparam logic [31:0] RDATA_IDLE = 32'h0000_0000;

  // Bus-state codes
  localparam logic [1:0] ST_OK = 2'h0;
  localparam logic [1:0] ST_WARN = 2'h1;
  localparam logic [1:0] ST_PASSIVE = 2'h2;
  localparam logic [1:0] ST_BUSOFF = 2'h3;

  // Sensitivity codes for status-change reporting
  localparam logic [1:0] SENS_NONE = 2'h0;
  localparam logic [1:0] SENS_BUSOFF = 2'h1;
  localparam logic [1:0] SENS_PASSIVE = 2'h2;
  localparam logic [1:0] SENS_ALL = 2'h3;

  // Error counter thresholds
  localparam logic [8:0] WARN_LIMIT = 9'h060;
  localparam logic [8:0] PASSIVE_LIMIT = 9'h080;
  localparam logic [8:0] BUSOFF_LIMIT = 9'h0FF;

  typedef struct packed {
    logic wake_irq_enable;
    logic status_change_irq_enable;
    logic [1:0] rx_state_sensitivity;
    logic [1:0] tx_state_sensitivity;
    logic overrun_irq_enable;
    logic rx_full_irq_enable;
  } crx_irq_en_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } crx_apb_req_t;
endpackage

// ### hdl/crx_flag_irq.sv
// Receive-side status flags, bus-state codes and interrupt enables with APB access
//
// Notes on behaviour
// - Write one clears flag; state codes read-only
// - Clear ignored while setting condition persists
// - Flag writes dropped during initialization mode
// - Flags held at reset in acknowledged init
// - State codes keep tracking during initialization
// - Wake flag: bus activity in sleep, enabled
// - Status-change flag set on bus-state change
// - State codes frozen while status-change flag pending
// - Receiver code OK below 96 errors
// - Transmitter code OK below 96 errors
// - Receiver shows bus-off with transmitter bus-off
// - Overrun flag set on receive overrun
// - Receive-full flag set on good message shift
// - Set receive-full blocks next foreground shift
// - Interrupt only when flag and enable set
// - Enable register layout, all reset zero
// - Receiver sensitivity selects reported changes
// - Transmitter sensitivity selects reported changes
// - Enables reset in init; sensitivities kept
//
// Local design decision: register access over APB.
`timescale 1ns/100ps
module crx_flag_irq (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic init_request,
  input wire logic init_acknowledge,
  input wire logic sleep_mode,
  input wire logic bus_activity,
  input wire logic wake_detect_enable,
  input wire logic overrun_event,
  input wire logic rx_msg_shift,
  input wire logic [8:0] tx_error_count,
  input wire logic [7:0] rx_error_count,
  output logic wake_irq,
  output logic error_irq,
  output logic rx_irq,
  output logic rx_shift_hold
);

  crx_pkg::crx_apb_req_t req;
  crx_pkg::crx_irq_en_t irq_en;
  logic wake_flag;
  logic status_change_flag;
  logic overrun_flag;
  logic [1:0] rx_state_code;
  logic [1:0] tx_state_code;
  logic [1:0] next_rx_code;
  logic [1:0] next_tx_code;
  logic in_init;
  logic init_idle;
  logic access;
  logic wr_done;
  logic wr_flag;
  logic wr_en;
  logic wake_cond;
  logic sc_cond;
  logic [7:0] flag_view;

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign in_init = init_request & init_acknowledge;
  assign init_idle = ~init_request & ~init_acknowledge;
  assign access = req.psel & req.penable;
  assign wr_done = access & pready & req.pwrite;
  assign wr_flag = wr_done & (req.paddr == crx_pkg::FLAG_ADDR) & init_idle;
  assign wr_en = wr_done & (req.paddr == crx_pkg::IRQ_EN_ADDR) & init_idle;

  // Actual bus state from the error counters
  always_comb begin
    if (tx_error_count < crx_pkg::WARN_LIMIT) begin
      next_tx_code = crx_pkg::ST_OK;
    end else if (tx_error_count < crx_pkg::PASSIVE_LIMIT) begin
      next_tx_code = crx_pkg::ST_WARN;
    end else if (tx_error_count <= crx_pkg::BUSOFF_LIMIT) begin
      next_tx_code = crx_pkg::ST_PASSIVE;
    end else begin
      next_tx_code = crx_pkg::ST_BUSOFF;
    end
    // Receiver has no bus-off of its own; it mirrors the transmitter
    if (tx_error_count > crx_pkg::BUSOFF_LIMIT) begin
      next_rx_code = crx_pkg::ST_BUSOFF;
    end else if ({1'b0, rx_error_count} < crx_pkg::WARN_LIMIT) begin
      next_rx_code = crx_pkg::ST_OK;
    end else if ({1'b0, rx_error_count} < crx_pkg::PASSIVE_LIMIT) begin
      next_rx_code = crx_pkg::ST_WARN;
    end else begin
      next_rx_code = crx_pkg::ST_PASSIVE;
    end
  end

  function automatic logic sens_hit(
    input logic [1:0] sens,
    input logic [1:0] old_code,
    input logic [1:0] new_code
  );
    logic hit;
    hit = 1'b0;
    case (sens)
      crx_pkg::SENS_NONE: hit = 1'b0;
      crx_pkg::SENS_BUSOFF: begin
        hit = (old_code == crx_pkg::ST_BUSOFF) | (new_code == crx_pkg::ST_BUSOFF);
      end
      crx_pkg::SENS_PASSIVE: begin
        hit = (old_code[1] | new_code[1]) & (old_code[1] != new_code[1] | old_code != new_code);
        hit = hit & (old_code[1] | new_code[1]);
      end
      default: hit = (old_code != new_code);
    endcase
    return hit & (old_code != new_code);
  endfunction

  assign sc_cond = ~status_change_flag & (
    sens_hit(irq_en.rx_state_sensitivity, rx_state_code, next_rx_code) |
    sens_hit(irq_en.tx_state_sensitivity, tx_state_code, next_tx_code));
  assign wake_cond = sleep_mode & bus_activity & wake_detect_enable;

  // Displayed codes only follow while no status change is pending; init does not touch them
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rx_state_code <= crx_pkg::ST_OK;
      tx_state_code <= crx_pkg::ST_OK;
    end else if (!status_change_flag) begin
      rx_state_code <= next_rx_code;
      tx_state_code <= next_tx_code;
    end
  end

  // Sticky flags: set wins over a write-one clear, so a live condition keeps its flag
  always_ff @(posedge ref_clk) begin
    if (rst || in_init) begin
      wake_flag <= crx_pkg::FLAG_RESET[crx_pkg::WAKE_BIT];
      status_change_flag <= crx_pkg::FLAG_RESET[crx_pkg::SC_BIT];
      overrun_flag <= crx_pkg::FLAG_RESET[crx_pkg::OVR_BIT];
      rx_shift_hold <= crx_pkg::FLAG_RESET[crx_pkg::RXF_BIT];
    end else begin
      if (wake_cond) begin
        wake_flag <= 1'b1;
      end else if (wr_flag && req.pwdata[crx_pkg::WAKE_BIT]) begin
        wake_flag <= 1'b0;
      end
      if (sc_cond) begin
        status_change_flag <= 1'b1;
      end else if (wr_flag && req.pwdata[crx_pkg::SC_BIT]) begin
        status_change_flag <= 1'b0;
      end
      if (overrun_event) begin
        overrun_flag <= 1'b1;
      end else if (wr_flag && req.pwdata[crx_pkg::OVR_BIT]) begin
        overrun_flag <= 1'b0;
      end
      // The flag itself is the hold that stops the next foreground shift
      if (rx_msg_shift) begin
        rx_shift_hold <= 1'b1;
      end else if (wr_flag && req.pwdata[crx_pkg::RXF_BIT]) begin
        rx_shift_hold <= 1'b0;
      end
    end
  end

  // Enable register; sensitivity fields survive initialization
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_en <= crx_pkg::IRQ_EN_RESET;
    end else if (in_init) begin
      irq_en.wake_irq_enable <= 1'b0;
      irq_en.status_change_irq_enable <= 1'b0;
      irq_en.overrun_irq_enable <= 1'b0;
      irq_en.rx_full_irq_enable <= 1'b0;
    end else if (wr_en) begin
      irq_en <= req.pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wake_irq <= 1'b0;
      error_irq <= 1'b0;
      rx_irq <= 1'b0;
    end else begin
      wake_irq <= wake_flag & irq_en.wake_irq_enable;
      error_irq <= (status_change_flag & irq_en.status_change_irq_enable) |
        (overrun_flag & irq_en.overrun_irq_enable);
      rx_irq <= rx_shift_hold & irq_en.rx_full_irq_enable;
    end
  end

  assign flag_view = {wake_flag, status_change_flag, rx_state_code, tx_state_code,
    overrun_flag, rx_shift_hold};

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= crx_pkg::RDATA_IDLE;
    end else if (access && !pready) begin
      pready <= 1'b1;
      pslverr <= (req.paddr != crx_pkg::FLAG_ADDR) && (req.paddr != crx_pkg::IRQ_EN_ADDR);
      if (!req.pwrite && req.paddr == crx_pkg::FLAG_ADDR) begin
        prdata <= {24'h00_0000, flag_view};
      end else if (!req.pwrite && req.paddr == crx_pkg::IRQ_EN_ADDR) begin
        prdata <= {24'h00_0000, irq_en};
      end else begin
        prdata <= crx_pkg::RDATA_IDLE;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= crx_pkg::RDATA_IDLE;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence s_ovr_clear;
    overrun_flag && wr_flag && req.pwdata[crx_pkg::OVR_BIT] && !overrun_event && !in_init;
  endsequence

  sequence s_rxf_clear;
    wr_flag && req.pwdata[crx_pkg::RXF_BIT] && !rx_msg_shift && !in_init;
  endsequence

  // A clear attempt while only one of the two init signals is high
  sequence s_half_init_ovr_clear;
    overrun_flag && !overrun_event && wr_done && req.pwdata[crx_pkg::OVR_BIT] &&
    !init_idle && !in_init && req.paddr == crx_pkg::FLAG_ADDR;
  endsequence

  a_w1c_clears_ovr: assert property (s_ovr_clear |=> !overrun_flag)
    else $error("overrun flag not cleared by write one");
  a_clear_needs_idle: assert property (
    overrun_event && !in_init |=> overrun_flag)
    else $error("overrun flag cleared while condition present");
  a_init_write_drop: assert property (
    wr_done && !init_idle && !in_init && req.paddr == crx_pkg::IRQ_EN_ADDR |=> $stable(irq_en))
    else $error("enable write accepted during init");
  a_flag_write_drop: assert property (s_half_init_ovr_clear |=> overrun_flag)
    else $error("flag write accepted during init");
  a_init_hold_flags: assert property (
    in_init |=> !wake_flag && !status_change_flag && !overrun_flag && !rx_shift_hold)
    else $error("flags not held in reset during init");
  a_codes_frozen: assert property (
    status_change_flag |=> $stable(rx_state_code) && $stable(tx_state_code))
    else $error("state code moved while status change pending");
  a_tx_ok_code: assert property (
    !status_change_flag && tx_error_count < crx_pkg::WARN_LIMIT
    |=> tx_state_code == crx_pkg::ST_OK)
    else $error("transmitter code not OK below limit");
  a_rx_ok_code: assert property (
    !status_change_flag && tx_error_count <= crx_pkg::BUSOFF_LIMIT &&
    {1'b0, rx_error_count} < crx_pkg::WARN_LIMIT |=> rx_state_code == crx_pkg::ST_OK)
    else $error("receiver code not OK below limit");
  a_rx_busoff_code: assert property (
    !status_change_flag && tx_error_count > crx_pkg::BUSOFF_LIMIT
    |=> rx_state_code == crx_pkg::ST_BUSOFF && tx_state_code == crx_pkg::ST_BUSOFF)
    else $error("receiver not bus-off with transmitter");
  a_sc_on_change: assert property (
    !status_change_flag && !in_init && irq_en.tx_state_sensitivity == crx_pkg::SENS_ALL &&
    next_tx_code != tx_state_code |=> status_change_flag)
    else $error("status change flag missed a state change");
  a_wake_set: assert property (wake_cond && !in_init |=> wake_flag)
    else $error("wake flag not set");
  a_rxf_hold: assert property (rx_msg_shift && !in_init |=> rx_shift_hold ##1
    (rx_shift_hold || $past(wr_flag) || $past(in_init)))
    else $error("receive full not set or released early");
  a_rxf_release: assert property (s_rxf_clear |=> !rx_shift_hold)
    else $error("receive full not released by clear");
  a_rx_irq_gate: assert property (
    rx_shift_hold && irq_en.rx_full_irq_enable && !in_init |=> rx_irq)
    else $error("receive interrupt missing");
  a_err_irq_mask: assert property (
    !overrun_flag && !(status_change_flag && irq_en.status_change_irq_enable) |=> !error_irq)
    else $error("error interrupt without enabled flag");
  a_init_en_reset: assert property (
    in_init |=> !irq_en.wake_irq_enable && !irq_en.rx_full_irq_enable &&
    $stable(irq_en.rx_state_sensitivity) && $stable(irq_en.tx_state_sensitivity))
    else $error("enable register not reset correctly in init");
  a_sens_none_quiet: assert property (
    !status_change_flag && irq_en.rx_state_sensitivity == crx_pkg::SENS_NONE &&
    irq_en.tx_state_sensitivity == crx_pkg::SENS_NONE |=> !status_change_flag)
    else $error("status change flag set with reporting off");
  a_rx_busoff_sens: assert property (
    !status_change_flag && !in_init && irq_en.rx_state_sensitivity == crx_pkg::SENS_BUSOFF &&
    next_rx_code != rx_state_code &&
    (next_rx_code == crx_pkg::ST_BUSOFF || rx_state_code == crx_pkg::ST_BUSOFF)
    |=> status_change_flag)
    else $error("receiver bus-off change not reported");
  a_tx_passive_sens: assert property (
    !status_change_flag && !in_init && irq_en.tx_state_sensitivity == crx_pkg::SENS_PASSIVE &&
    next_tx_code != tx_state_code && (next_tx_code[1] || tx_state_code[1])
    |=> status_change_flag)
    else $error("transmitter passive change not reported");
  a_wake_irq_gate: assert property (wake_flag && irq_en.wake_irq_enable |=> wake_irq)
    else $error("wake interrupt missing");
  a_ovr_irq_gate: assert property (
    overrun_flag && irq_en.overrun_irq_enable |=> error_irq)
    else $error("overrun interrupt missing");

endmodule // crx_flag_irq

// ### sim/crx_far_side.sv
// Far-side model: error counters, overrun, bus activity and message shifts
`timescale 1ns/100ps
module crx_far_side (
  input wire logic ref_clk,
  input wire logic rx_shift_hold,
  output logic bus_activity,
  output logic overrun_event,
  output logic rx_msg_shift,
  output logic [8:0] tx_error_count,
  output logic [7:0] rx_error_count
);
  initial begin
    bus_activity = 1'b0;
    overrun_event = 1'b0;
    rx_msg_shift = 1'b0;
    tx_error_count = 9'h000;
    rx_error_count = 8'h00;
  end
  task set_counts(input logic [8:0] t, input logic [7:0] r);
    @(posedge ref_clk);
    tx_error_count <= t;
    rx_error_count <= r;
  endtask
  task set_lines(input logic ovr, input logic act);
    @(posedge ref_clk);
    overrun_event <= ovr;
    bus_activity <= act;
  endtask
  // A waiting message is held back while the foreground buffer is still owned by software
  task shift_msg(output logic stuck);
    int i;
    i = 0;
    @(posedge ref_clk);
    while (rx_shift_hold !== 1'b0 && i < 50) begin
      @(posedge ref_clk);
      i++;
    end
    // A buffer never released is reported, not overwritten
    stuck = (rx_shift_hold !== 1'b0);
    if (!stuck) begin
      rx_msg_shift <= 1'b1;
      @(posedge ref_clk);
      rx_msg_shift <= 1'b0;
    end
  endtask
endmodule // crx_far_side

// ### sim/testbench.sv
// Self-checking bench: register access, flags, bus-state codes and interrupt enables
`timescale 1ns/100ps
module testbench;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, e, stuck;
  logic init_request, init_acknowledge, sleep_mode, wake_detect_enable;
  logic bus_activity, overrun_event, rx_msg_shift;
  logic wake_irq, error_irq, rx_irq, rx_shift_hold;
  logic [7:0] paddr, rx_error_count;
  logic [8:0] tx_error_count;
  logic [31:0] pwdata, prdata, r;
  int n_fail = 0;
  int n_tests = 0;
  localparam logic [8:0] TV [7] = '{9'h060, 9'h080, 9'h100, 9'h000, 9'h000, 9'h000, 9'h000};
  localparam logic [7:0] RV [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h64, 8'hC8, 8'h5F};
  localparam logic [7:0] CV [7] = '{8'h04, 8'h08, 8'h3C, 8'h00, 8'h10, 8'h20, 8'h00};

  crx_flag_irq dut (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .init_request, .init_acknowledge, .sleep_mode, .bus_activity,
    .wake_detect_enable, .overrun_event, .rx_msg_shift, .tx_error_count, .rx_error_count,
    .wake_irq, .error_irq, .rx_irq, .rx_shift_hold);
  crx_far_side far (.ref_clk, .rx_shift_hold, .bus_activity, .overrun_event, .rx_msg_shift,
    .tx_error_count, .rx_error_count);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  task bchk(input string n, input logic x, input logic g);
    chk(n, 32'(x), 32'(g));
  endtask
  // Request is held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    i = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    apb(1'b0, a, 8'h00);
    chk("register", {24'h00_0000, x}, r);
  endtask
  task ovr_pulse();
    far.set_lines(1'b1, 1'b0);
    far.set_lines(1'b0, 1'b0);
  endtask

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, init_request, init_acknowledge, sleep_mode} = 6'h00;
    wake_detect_enable = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rd(crx_pkg::FLAG_ADDR, 8'h00);
    rd(crx_pkg::IRQ_EN_ADDR, 8'h00);
    apb(1'b0, 8'h20, 8'h00);
    bchk("pslverr", 1'b1, e);
    chk("unmapped data", 32'h0000_0000, r);
    wr(crx_pkg::IRQ_EN_ADDR, 8'hFF);
    rd(crx_pkg::IRQ_EN_ADDR, 8'hFF);
    ovr_pulse();
    rd(crx_pkg::FLAG_ADDR, 8'h02);
    bchk("error_irq", 1'b1, error_irq);
    wr(crx_pkg::FLAG_ADDR, 8'h00);
    rd(crx_pkg::FLAG_ADDR, 8'h02);
    wr(crx_pkg::FLAG_ADDR, 8'h3E);
    rd(crx_pkg::FLAG_ADDR, 8'h00);
    bchk("error_irq", 1'b0, error_irq);
    far.set_lines(1'b1, 1'b0);
    wr(crx_pkg::FLAG_ADDR, 8'h02);
    rd(crx_pkg::FLAG_ADDR, 8'h02);
    far.set_lines(1'b0, 1'b0);
    wr(crx_pkg::FLAG_ADDR, 8'h02);
    rd(crx_pkg::FLAG_ADDR, 8'h00);
    far.shift_msg(stuck);
    if (stuck) begin
      n_fail++;
      give_verdict();
    end
    rd(crx_pkg::FLAG_ADDR, 8'h01);
    bchk("rx_shift_hold", 1'b1, rx_shift_hold);
    bchk("rx_irq", 1'b1, rx_irq);
    wr(crx_pkg::FLAG_ADDR, 8'h01);
    rd(crx_pkg::FLAG_ADDR, 8'h00);
    wr(crx_pkg::IRQ_EN_ADDR, 8'h3C);
    ovr_pulse();
    rd(crx_pkg::FLAG_ADDR, 8'h02);
    bchk("error_irq", 1'b0, error_irq);
    wr(crx_pkg::FLAG_ADDR, 8'h02);
    for (int k = 0; k < 7; k++) begin
      far.set_counts(TV[k], RV[k]);
      rd(crx_pkg::FLAG_ADDR, 8'h40 | CV[k]);
      wr(crx_pkg::FLAG_ADDR, 8'h40);
      rd(crx_pkg::FLAG_ADDR, CV[k]);
    end
    far.set_counts(9'h060, 8'h00);
    far.set_counts(9'h032, 8'h00);
    rd(crx_pkg::FLAG_ADDR, 8'h44);
    far.set_counts(9'h060, 8'h00);
    wr(crx_pkg::FLAG_ADDR, 8'h40);
    rd(crx_pkg::FLAG_ADDR, 8'h04);
    wr(crx_pkg::IRQ_EN_ADDR, 8'hC3);
    far.set_counts(9'h000, 8'h00);
    rd(crx_pkg::FLAG_ADDR, 8'h00);
    wr(crx_pkg::IRQ_EN_ADDR, 8'h18);
    far.set_counts(9'h060, 8'h64);
    rd(crx_pkg::FLAG_ADDR, 8'h14);
    far.set_counts(9'h080, 8'h64);
    rd(crx_pkg::FLAG_ADDR, 8'h58);
    wr(crx_pkg::FLAG_ADDR, 8'h40);
    wr(crx_pkg::IRQ_EN_ADDR, 8'h10);
    far.set_counts(9'h100, 8'h64);
    rd(crx_pkg::FLAG_ADDR, 8'h7C);
    wr(crx_pkg::FLAG_ADDR, 8'h40);
    far.set_counts(9'h000, 8'h00);
    rd(crx_pkg::FLAG_ADDR, 8'h40);
    wr(crx_pkg::FLAG_ADDR, 8'h40);
    wr(crx_pkg::IRQ_EN_ADDR, 8'h20);
    far.set_counts(9'h000, 8'h80);
    rd(crx_pkg::FLAG_ADDR, 8'h60);
    wr(crx_pkg::FLAG_ADDR, 8'h40);
    far.set_counts(9'h000, 8'h64);
    rd(crx_pkg::FLAG_ADDR, 8'h50);
    wr(crx_pkg::FLAG_ADDR, 8'h40);
    far.set_counts(9'h000, 8'h00);
    rd(crx_pkg::FLAG_ADDR, 8'h00);
    wr(crx_pkg::IRQ_EN_ADDR, 8'hFF);
    @(posedge ref_clk);
    init_request <= 1'b1;
    init_acknowledge <= 1'b1;
    ovr_pulse();
    far.set_counts(9'h060, 8'h00);
    rd(crx_pkg::FLAG_ADDR, 8'h04);
    rd(crx_pkg::IRQ_EN_ADDR, 8'h3C);
    wr(crx_pkg::IRQ_EN_ADDR, 8'h00);
    far.set_counts(9'h000, 8'h00);
    @(posedge ref_clk);
    init_request <= 1'b0;
    init_acknowledge <= 1'b0;
    rd(crx_pkg::IRQ_EN_ADDR, 8'h3C);
    rd(crx_pkg::FLAG_ADDR, 8'h00);
    @(posedge ref_clk);
    init_request <= 1'b1;
    ovr_pulse();
    wr(crx_pkg::FLAG_ADDR, 8'h02);
    wr(crx_pkg::IRQ_EN_ADDR, 8'h00);
    rd(crx_pkg::FLAG_ADDR, 8'h02);
    rd(crx_pkg::IRQ_EN_ADDR, 8'h3C);
    init_request <= 1'b0;
    wr(crx_pkg::FLAG_ADDR, 8'h02);
    rd(crx_pkg::FLAG_ADDR, 8'h00);
    wr(crx_pkg::IRQ_EN_ADDR, 8'h80);
    @(posedge ref_clk);
    sleep_mode <= 1'b1;
    wake_detect_enable <= 1'b1;
    far.set_lines(1'b0, 1'b1);
    far.set_lines(1'b0, 1'b0);
    rd(crx_pkg::FLAG_ADDR, 8'h80);
    bchk("wake_irq", 1'b1, wake_irq);
    sleep_mode <= 1'b0;
    wr(crx_pkg::FLAG_ADDR, 8'h80);
    rd(crx_pkg::FLAG_ADDR, 8'h00);
    give_verdict();
  end
endmodule // testbench
